// file: src/elapsed_time_event_recorder.sv
// Behaviour
// R1: Count each falling edge of activity in a retained 16-bit event count.
// R2: Accumulate high time of activity in a retained 32-bit elapsed-time count.
// R3: One elapsed-time step equals a quarter second of high time.
// R4: Alert when elapsed time reaches or exceeds its limit.
// R5: Alert when event count reaches or exceeds its limit.
// R6: Polarity bit picks pull-low or released as the active alert state.
// R7: Sixteen bytes of retained user memory, readable and writable by host.
// R8: Hold a four-byte password value.
// R9: After alert clear, re-evaluate and set again within 10 to 150 us.
// R10: Host retained write starts at stop and lasts at most 20 ms.
// R11: End of activity stores updated counts during the next write period.
// R12: Falling edge adds one event and stops elapsed-time advance.
// R13: Host writes refused while activity is high; host must not try.
// R14: Alert stays until condition gone and clear issued.
// R15: Each limit comparison has its own enable gating the alert.
// R16: Quarter-second tick from a prescaler advances time only while high.
`timescale 1ns/100ps
module elapsed_time_event_recorder
   import recorder_pkg::*;
#(
   parameter int unsigned TICK_LEN = TICK_CYCLES,
   parameter int unsigned DEGLITCH_LEN = DEGLITCH_CYCLES,
   parameter int unsigned NV_WRITE_LEN = NV_WRITE_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic activity_in,
   input wire logic alert_clear_command,
   input wire logic alert_polarity_bit,
   input wire logic time_limit_enable,
   input wire logic event_limit_enable,
   input wire logic [31:0] time_limit,
   input wire logic [15:0] event_limit,
   input wire logic host_wr_valid,
   input wire logic host_wr_password,
   input wire logic [3:0] host_wr_addr,
   input wire logic [7:0] host_wr_data,
   input wire logic stop_seen,
   input wire logic [3:0] mem_rd_addr,
   input wire logic [31:0] password_try,
   output logic [7:0] mem_rd_data,
   output logic password_match,
   output logic [31:0] elapsed_time_counter,
   output logic [15:0] event_count,
   output logic [31:0] stored_time,
   output logic [15:0] stored_events,
   output logic activity,
   output logic write_refused,
   output logic nonvolatile_write_period,
   output logic alert_active,
   output logic alert_pin_out,
   output logic alert_pin_oe
);
   logic sync0, sync1, active_d, tick, counts_pending, host_pending;
   logic [31:0] glitch_count, nv_count;
   logic [15:0] holdoff;
   logic [7:0] user_mem [USER_MEM_BYTES];
   logic [7:0] password [PASSWORD_BYTES];
   logic pend_password;
   logic [3:0] pend_addr;
   logic [7:0] pend_data;
   nv_state_t nv_state;
   logic rise, fall, cond, commit_host;

   assign rise = activity && !active_d;
   assign fall = !activity && active_d;
   assign commit_host = (nv_state == NV_HOST) && (nv_count == NV_WRITE_LEN - 1);
   assign cond = (time_limit_enable && elapsed_time_counter >= time_limit) // R4 R15
      || (event_limit_enable && event_count >= event_limit); // R5 R15

   // ------------------------------------------------------------
   // Activity input: synchroniser and deglitch filter
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync0 <= 1'b0;
         sync1 <= 1'b0;
      end else begin
         sync0 <= activity_in;
         sync1 <= sync0;
      end
   end

   // Level accepted only after staying put for the deglitch time
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         glitch_count <= 32'h0000_0000;
         activity <= 1'b0;
         active_d <= 1'b0;
      end else begin
         active_d <= activity;
         if (sync1 == activity) begin
            glitch_count <= 32'h0000_0000;
         end else if (glitch_count == DEGLITCH_LEN - 1) begin
            glitch_count <= 32'h0000_0000;
            activity <= sync1;
         end else begin
            glitch_count <= glitch_count + 32'h0000_0001;
         end
      end
   end

   tick_prescaler #(.PERIOD(TICK_LEN)) u_tick (
      .clk(clk),
      .rst(rst),
      .run(activity),
      .tick(tick)
   );

   // ------------------------------------------------------------
   // Working counters
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         elapsed_time_counter <= TIME_RESET;
         event_count <= EVENT_RESET;
      end else if (rise) begin
         elapsed_time_counter <= stored_time;
         event_count <= stored_events;
      end else if (fall) begin
         event_count <= event_count + 16'h0001; // R1 R12
      end else if (activity && tick) begin
         elapsed_time_counter <= elapsed_time_counter + 32'h0000_0001; // R2 R3 R16
      end
   end

   // ------------------------------------------------------------
   // Host write capture, refused while activity is high
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         host_pending <= 1'b0;
         pend_password <= 1'b0;
         pend_addr <= 4'h0;
         pend_data <= 8'h00;
         write_refused <= 1'b0;
      end else begin
         write_refused <= host_wr_valid && (activity || nonvolatile_write_period); // R13
         if (host_wr_valid && !activity && !nonvolatile_write_period) begin
            host_pending <= 1'b1;
            pend_password <= host_wr_password;
            pend_addr <= host_wr_addr;
            pend_data <= host_wr_data;
         end else if (nv_state == NV_IDLE && !counts_pending && stop_seen) begin
            host_pending <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Nonvolatile write sequencer
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         nv_state <= NV_IDLE;
         nv_count <= 32'h0000_0000;
         counts_pending <= 1'b0;
         nonvolatile_write_period <= 1'b0;
         stored_time <= TIME_RESET;
         stored_events <= EVENT_RESET;
      end else begin
         if (fall) begin
            counts_pending <= 1'b1; // R11
         end
         case (nv_state)
            NV_IDLE: begin
               nv_count <= 32'h0000_0000;
               if (counts_pending && !activity) begin
                  nv_state <= NV_COUNT; // R11
                  counts_pending <= fall;
                  nonvolatile_write_period <= 1'b1;
               end else if (host_pending && stop_seen) begin
                  nv_state <= NV_HOST; // R10
                  nonvolatile_write_period <= 1'b1;
               end
            end
            NV_HOST, NV_COUNT: begin
               if (nv_count == NV_WRITE_LEN - 1) begin
                  nv_state <= NV_IDLE;
                  nonvolatile_write_period <= 1'b0;
                  if (nv_state == NV_COUNT) begin
                     stored_time <= elapsed_time_counter; // R2 R11
                     stored_events <= event_count; // R1 R11
                  end
               end else begin
                  nv_count <= nv_count + 32'h0000_0001; // R10
               end
            end
            default: begin
               nv_state <= NV_IDLE;
               nonvolatile_write_period <= 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Retained user memory and password, written at end of period
   // ------------------------------------------------------------
   for (genvar i = 0; i < USER_MEM_BYTES; i++) begin : g_mem
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            user_mem[i] <= MEM_RESET;
         end else if (commit_host && !pend_password && pend_addr == 4'(i)) begin
            user_mem[i] <= pend_data; // R7
         end
      end
   end

   for (genvar j = 0; j < PASSWORD_BYTES; j++) begin : g_pw
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            password[j] <= PASSWORD_RESET;
         end else if (commit_host && pend_password && pend_addr[1:0] == 2'(j)) begin
            password[j] <= pend_data; // R8
         end
      end
   end

   // Registered read port and password compare
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mem_rd_data <= 8'h00;
         password_match <= 1'b0;
      end else begin
         mem_rd_data <= user_mem[mem_rd_addr]; // R7
         password_match <= password_try == {password[3],password[2],password[1],password[0]}; // R8
      end
   end

   // ------------------------------------------------------------
   // Alert latch with clear hold-off
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         alert_active <= 1'b0;
         holdoff <= 16'h0000;
      end else if (alert_clear_command) begin
         alert_active <= 1'b0; // R14
         holdoff <= 16'(CLEAR_SET_CYCLES); // R9
      end else if (holdoff != 16'h0000) begin
         holdoff <= holdoff - 16'h0001;
      end else if (cond) begin
         alert_active <= 1'b1; // R4 R5 R9
      end
   end

   // Open-drain pin: drives low when enabled
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         alert_pin_out <= 1'b0;
         alert_pin_oe <= 1'b0;
      end else begin
         alert_pin_out <= 1'b0;
         alert_pin_oe <= alert_active ^ alert_polarity_bit; // R6
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   event_incr_a: assert property (fall |=> event_count == $past(event_count) + 16'h0001) // R1
      else $error("event count did not step on falling edge");
   time_step_a: assert property (activity && tick && !rise |=>
      elapsed_time_counter == $past(elapsed_time_counter) + 32'h0000_0001) // R3
      else $error("elapsed time did not step on tick");
   time_hold_a: assert property (!activity && !active_d |=> $stable(elapsed_time_counter)) // R12
      else $error("elapsed time moved while inactive");
   time_alert_a: assert property (time_limit_enable && elapsed_time_counter >= time_limit
      && holdoff == 16'h0000 && !alert_clear_command |=> alert_active) // R4
      else $error("time limit did not raise alert");
   event_alert_a: assert property (event_limit_enable && event_count >= event_limit
      && holdoff == 16'h0000 && !alert_clear_command |=> alert_active) // R5
      else $error("event limit did not raise alert");
   alert_pin_a: assert property (alert_active && $stable(alert_active)
      && $stable(alert_polarity_bit) |=> alert_pin_oe == !$past(alert_polarity_bit)) // R6
      else $error("alert pin state wrong for polarity");
   clear_gap_a: assert property (alert_clear_command ##1 !alert_clear_command [*8]
      |-> !alert_active) // R9
      else $error("alert set again too early after clear");
   enable_gate_a: assert property (!time_limit_enable && !event_limit_enable && !alert_active
      |=> !alert_active) // R15
      else $error("alert raised with both comparisons disabled");
   refuse_write_a: assert property (host_wr_valid && activity |=> write_refused) // R13
      else $error("write not refused while active");
   host_start_a: assert property (nv_state == NV_IDLE && host_pending && !counts_pending
      && !stop_seen |=> nv_state == NV_IDLE) // R10
      else $error("host write period started before stop");
   period_len_a: assert property (nv_count <= NV_WRITE_LEN - 1) // R10
      else $error("write period overran");
   count_store_a: assert property (nv_state == NV_COUNT && nv_count == NV_WRITE_LEN - 1
      |=> stored_events == $past(event_count)) // R11
      else $error("counts not stored at end of period");

   alert_cov_c: cover property (!alert_active ##1 alert_active);
   reraise_cov_c: cover property (holdoff == 16'h0001 ##1 !alert_active ##1 alert_active);
   host_commit_cov_c: cover property (commit_host);
   activity_cycle_cov_c: cover property (rise ##[1:1000] fall);
endmodule // elapsed_time_event_recorder

// file: src/recorder_pkg.sv
package recorder_pkg;
   // ------------------------------------------------------------
   // Clock and timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned TICK_MS = 250;
   localparam int unsigned TICK_CYCLES = TICK_MS * 1000000 / CLK_PERIOD_NS;
   localparam int unsigned DEGLITCH_MS = 10;
   localparam int unsigned DEGLITCH_CYCLES = DEGLITCH_MS * 1000000 / CLK_PERIOD_NS;
   localparam int unsigned NV_WRITE_MS = 20;
   localparam int unsigned NV_WRITE_CYCLES = NV_WRITE_MS * 1000000 / CLK_PERIOD_NS;
   localparam int unsigned CLEAR_SET_US = 10;
   localparam int unsigned CLEAR_SET_CYCLES = (CLEAR_SET_US * 1000 + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS;

   // ------------------------------------------------------------
   // Sizes and reset values
   // ------------------------------------------------------------
   localparam int unsigned USER_MEM_BYTES = 16;
   localparam int unsigned PASSWORD_BYTES = 4;
   localparam logic [31:0] TIME_RESET = 32'h0000_0000;
   localparam logic [15:0] EVENT_RESET = 16'h0000;
   localparam logic [7:0] MEM_RESET = 8'hFF;
   localparam logic [7:0] PASSWORD_RESET = 8'hFF;

   // Nonvolatile write sequencer states
   typedef enum logic [2:0] {
      NV_IDLE = 3'b001,
      NV_HOST = 3'b010,
      NV_COUNT = 3'b100
   } nv_state_t;
endpackage

// file: src/tick_prescaler.sv
`timescale 1ns/100ps
module tick_prescaler
   import recorder_pkg::*;
#(
   parameter int unsigned PERIOD = TICK_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic run,
   output logic tick
);
   logic [31:0] count;

   // ------------------------------------------------------------
   // Divider, restarts whenever run drops
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count <= 32'h0000_0000;
         tick <= 1'b0;
      end else if (!run) begin
         count <= 32'h0000_0000;
         tick <= 1'b0;
      end else if (count == PERIOD - 1) begin
         count <= 32'h0000_0000;
         tick <= 1'b1; // R16
      end else begin
         count <= count + 32'h0000_0001;
         tick <= 1'b0;
      end
   end
endmodule // tick_prescaler

// file: verif/host_model.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Host side of the byte write port
// ------------------------------------------------------------
module host_model (
   input wire logic clk,
   input wire logic activity,
   input wire logic nonvolatile_write_period,
   output logic host_wr_valid,
   output logic host_wr_password,
   output logic [3:0] host_wr_addr,
   output logic [7:0] host_wr_data,
   output logic stop_seen,
   output logic alert_clear_command
);
   // Idle levels at time zero
   initial begin
      host_wr_valid = 1'b0;
      host_wr_password = 1'b0;
      host_wr_addr = 4'h0;
      host_wr_data = 8'h00;
      stop_seen = 1'b0;
      alert_clear_command = 1'b0;
   end

   // One byte then a stop; waits out busy states unless told to push
   task automatic write_byte(input logic pw, input logic [3:0] a, input logic [7:0] d,
      input logic push);
      int n = 0;
      while (!push && (activity || nonvolatile_write_period) && n < 200) begin
         @(posedge clk);
         n++;
      end
      host_wr_valid <= 1'b1;
      host_wr_password <= pw;
      host_wr_addr <= a;
      host_wr_data <= d;
      @(posedge clk);
      host_wr_valid <= 1'b0;
      host_wr_addr <= ~a; // Released lines do not keep the last value
      host_wr_data <= ~d;
      stop_seen <= 1'b1;
      @(posedge clk);
      stop_seen <= 1'b0;
      @(posedge clk);
   endtask

   // One-cycle alert clear pulse
   task automatic clear_alert();
      alert_clear_command <= 1'b1;
      @(posedge clk);
      alert_clear_command <= 1'b0;
   endtask
endmodule // host_model

// file: verif/testbench.sv
`timescale 1ns/100ps
module testbench;
   import recorder_pkg::*;
   localparam int unsigned TL = 8;
   localparam int unsigned DL = 3;
   localparam int unsigned WL = 10;
   logic clk, rst, activity_in, alert_polarity_bit, time_limit_enable, event_limit_enable;
   logic [31:0] time_limit, password_try, t;
   logic [15:0] event_limit;
   logic [3:0] mem_rd_addr;
   logic host_wr_valid, host_wr_password, stop_seen, alert_clear_command;
   logic [3:0] host_wr_addr;
   logic [7:0] host_wr_data, mem_rd_data;
   logic password_match, activity, write_refused, nonvolatile_write_period;
   logic alert_active, alert_pin_out, alert_pin_oe;
   logic [31:0] elapsed_time_counter, stored_time;
   logic [15:0] event_count, stored_events;
   int bad_count = 0;
   int cmp_count = 0;
   int refused_seen = 0;
   int n;

   // ------------------------------------------------------------
   // Design and host model
   // ------------------------------------------------------------
   elapsed_time_event_recorder #(.TICK_LEN(TL), .DEGLITCH_LEN(DL), .NV_WRITE_LEN(WL))
   elapsed_time_event_recorder_inst (
      .clk(clk), .rst(rst), .activity_in(activity_in),
      .alert_clear_command(alert_clear_command), .alert_polarity_bit(alert_polarity_bit),
      .time_limit_enable(time_limit_enable), .event_limit_enable(event_limit_enable),
      .time_limit(time_limit), .event_limit(event_limit), .host_wr_valid(host_wr_valid),
      .host_wr_password(host_wr_password), .host_wr_addr(host_wr_addr),
      .host_wr_data(host_wr_data), .stop_seen(stop_seen), .mem_rd_addr(mem_rd_addr),
      .password_try(password_try), .mem_rd_data(mem_rd_data),
      .password_match(password_match), .elapsed_time_counter(elapsed_time_counter),
      .event_count(event_count), .stored_time(stored_time), .stored_events(stored_events),
      .activity(activity), .write_refused(write_refused),
      .nonvolatile_write_period(nonvolatile_write_period), .alert_active(alert_active),
      .alert_pin_out(alert_pin_out), .alert_pin_oe(alert_pin_oe)
   );
   host_model host_model_inst (
      .clk(clk), .activity(activity), .nonvolatile_write_period(nonvolatile_write_period),
      .host_wr_valid(host_wr_valid), .host_wr_password(host_wr_password),
      .host_wr_addr(host_wr_addr), .host_wr_data(host_wr_data), .stop_seen(stop_seen),
      .alert_clear_command(alert_clear_command)
   );

   // ------------------------------------------------------------
   // Clock, monitors and helpers
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Counts refused-write pulses
   always @(posedge clk) begin
      if (write_refused === 1'b1) refused_seen <= refused_seen + 1;
   end

   // Watchdog cuts a hang short
   initial begin
      #100000;
      bad_count++;
      stop_test();
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask

   task automatic wait_act(input logic lvl);
      int k = 0;
      while (activity !== lvl && k < 50) begin
         @(posedge clk);
         k++;
      end
   endtask

   task automatic wait_idle();
      int k = 0;
      while (nonvolatile_write_period !== 1'b0 && k < 100) begin
         @(posedge clk);
         k++;
      end
   endtask

   task automatic stop_test();
      if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------
   initial begin
      rst = 1'b1;
      activity_in = 1'b0;
      alert_polarity_bit = 1'b0;
      time_limit_enable = 1'b0;
      event_limit_enable = 1'b0;
      time_limit = 32'hFFFFFFFF;
      event_limit = 16'hFFFF;
      mem_rd_addr = 4'h0;
      password_try = 32'hFFFFFFFF;
      cyc(2);
      rst <= 1'b0;
      cyc(2);
      #1;
      check("time count", elapsed_time_counter, 32'h0);
      check("event count", 32'(event_count), 32'h0);
      check("mem reset", 32'(mem_rd_data), 32'hFF);
      check("password reset", 32'(password_match), 32'h1);
      check("alert oe", 32'(alert_pin_oe), 32'h0);
      // Password bytes and one user memory byte
      @(posedge clk);
      for (int i = 0; i < 4; i++) host_model_inst.write_byte(1'b1, 4'(i), 8'(17 * (i + 1)), 1'b0);
      host_model_inst.write_byte(1'b0, 4'h3, 8'h5A, 1'b0);
      n = 0;
      while (nonvolatile_write_period === 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
      end
      check("write period", 32'(n > 0 && n <= WL), 32'h1);
      mem_rd_addr <= 4'h3;
      password_try <= 32'h44332211;
      cyc(2);
      #1;
      check("mem byte", 32'(mem_rd_data), 32'h5A);
      check("password", 32'(password_match), 32'h1);
      check("no refusal", refused_seen, 32'h0);
      // Activity high: ticks and a refused write
      @(posedge clk);
      activity_in <= 1'b1;
      wait_act(1'b1);
      cyc(5 * TL + 3);
      #1;
      check("ticks", elapsed_time_counter, 32'h5);
      @(posedge clk);
      host_model_inst.write_byte(1'b0, 4'h3, 8'hA5, 1'b1);
      check("refused", refused_seen, 32'h1);
      // Fall: event counted, time frozen, counts stored
      activity_in <= 1'b0;
      wait_act(1'b0);
      #1;
      check("event fall", 32'(event_count), 32'h1);
      t = elapsed_time_counter;
      cyc(3 * TL);
      check("time frozen", elapsed_time_counter, t);
      wait_idle();
      #1;
      check("stored time", stored_time, t);
      check("stored events", 32'(stored_events), 32'h1);
      check("mem kept", 32'(mem_rd_data), 32'h5A);
      // Alert limits and enables
      @(posedge clk);
      event_limit <= 16'h0001;
      time_limit <= t;
      cyc(4);
      #1;
      check("disabled", 32'(alert_active), 32'h0);
      @(posedge clk);
      time_limit <= t + 1;
      time_limit_enable <= 1'b1;
      cyc(4);
      #1;
      check("below limit", 32'(alert_active), 32'h0);
      @(posedge clk);
      time_limit <= t;
      cyc(2);
      #1;
      check("time alert", 32'(alert_active), 32'h1);
      cyc(1);
      #1;
      check("pull low", 32'(alert_pin_oe), 32'h1);
      check("pin data", 32'(alert_pin_out), 32'h0);
      @(posedge clk);
      alert_polarity_bit <= 1'b1;
      cyc(2);
      #1;
      check("released", 32'(alert_pin_oe), 32'h0);
      @(posedge clk);
      time_limit_enable <= 1'b0;
      event_limit_enable <= 1'b1;
      host_model_inst.clear_alert();
      #1;
      check("cleared", 32'(alert_active), 32'h0);
      n = 0;
      while (alert_active !== 1'b1 && n < 40000) begin
         @(posedge clk);
         n++;
      end
      check("reset window", 32'(n >= 2000 && n <= 30000), 32'h1);
      event_limit_enable <= 1'b0;
      cyc(5);
      #1;
      check("alert held", 32'(alert_active), 32'h1);
      @(posedge clk);
      host_model_inst.clear_alert();
      cyc(2100);
      #1;
      check("alert gone", 32'(alert_active), 32'h0);
      stop_test();
   end
endmodule // testbench
